// File: hw/ewl_defs.vh
// constants for the nvm write-done interrupt and wake-up block
// assumes plain verilog-2005, included by bare name
`ifndef EWL_DEFS_VH
`define EWL_DEFS_VH

`define EWL_ADDR_CTRL     12'h000
`define EWL_ADDR_FLAGS    12'h004
`define EWL_ADDR_FLAG_SET 12'h008
`define EWL_ADDR_FLAG_CLR 12'h00c
`define EWL_ADDR_STATUS   12'h010
`define EWL_ADDR_IRQ_STS  12'h014
`define EWL_ADDR_IRQ_CLR  12'h018
`define EWL_ADDR_IRQ_EN   12'h01c
`define EWL_ADDR_LOWPWR   12'h020

// ctrl fields
`define EWL_CTRL_GIE      0
`define EWL_CTRL_NVM_EN   1
`define EWL_CTRL_GRP_EN   2
// flag fields
`define EWL_FLG_NVM       0
`define EWL_FLG_GRP       1
// status fields
`define EWL_ST_STACK_FULL 0
`define EWL_ST_ASLEEP     1
`define EWL_ST_IN_ISR     2
// irq event fields
`define EWL_EV_VECTOR     0
`define EWL_EV_WAKE       1
`define EWL_EV_NVM_DONE   2

`define EWL_CTRL_RST      3'h0
`define EWL_GIE_RST       1'b0
`define EWL_WAKE_PULSE    1

`endif

// File: hw/ewl_irq_wake.v
// nvm write-done interrupt source, group request, vector call and wake-up
// assumes an apb master on sys_clk and a core that acks vector calls and returns
//
// Contract
// - nvm write completion sets the write-done flag, feeding the group request.
// - vector call needs global, source and group enables, event, and stack room.
// - taking the vector clears the global interrupt enable.
// - service clears only the group flag; source flag needs software clear.
// - in sleep any nvm or external flag rising edge wakes, enables ignored.
// - async flag sources set flags only through sys_clk synchronisers, not while the oscillator is stopped.
// - flags persist until serviced or cleared; enables only block servicing.
// - entry pushes only the program counter; core saves nothing else.
// - interrupt return resumes and sets the global enable again.
// - plain return resumes and leaves the global enable unchanged.
`timescale 1ns/100ps
`include "ewl_defs.vh"

module ewl_irq_wake #(
  parameter EXT_SRC = 2
) (
  input  wire                sys_clk,
  input  wire                rst_b,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  input  wire [3:0]          pstrb,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire                nvm_write_busy,
  input  wire [EXT_SRC-1:0]  ext_src_async,
  input  wire                stack_full,
  input  wire                vector_ack,
  input  wire                return_from_irq_instr,
  input  wire                return_instr,
  output reg                 vector_req,
  output reg                 push_pc,
  output reg                 wake_req,
  output reg                 global_irq_enable,
  output reg                 irq
);

  localparam ST_IDLE = 3'b001;
  localparam ST_CALL = 3'b010;
  localparam ST_ISR  = 3'b100;

  reg  [2:0]          state;
  reg  [2:0]          next_state;
  reg                 nvm_busy_d;
  reg                 nvm_write_done_flag;
  reg                 nvm_write_done_enable;
  reg                 group_enable;
  reg                 group_request_flag;
  reg  [EXT_SRC-1:0]  ext_meta;
  reg  [EXT_SRC-1:0]  ext_sync;
  reg  [EXT_SRC-1:0]  ext_sync_d;
  reg  [EXT_SRC-1:0]  ext_flag;
  reg  [EXT_SRC:0]    flags_d;
  reg                 asleep;
  reg  [2:0]          irq_sts;
  reg  [2:0]          irq_en;
  reg  [31:0]         next_prdata;

  wire                wr_acc;
  wire                rd_acc;
  wire                addr_ok;
  wire                nvm_done_pulse;
  wire [EXT_SRC:0]    all_flags;
  wire                flag_rise;
  wire                take_vector;
  wire [2:0]          ev;
  wire                wr_ctrl;
  wire                wr_flag_set;
  wire                wr_flag_clr;
  wire                wr_irq_clr;
  wire                wr_irq_en;
  wire                wr_lowpwr;
  wire                in_isr;
  wire                return_from_irq_instr_seen;

  assign wr_acc = psel & penable & pwrite & ~pready;
  assign rd_acc = psel & penable & ~pwrite & ~pready;
  assign addr_ok = (paddr == `EWL_ADDR_CTRL) | (paddr == `EWL_ADDR_FLAGS) |
                   (paddr == `EWL_ADDR_FLAG_SET) | (paddr == `EWL_ADDR_FLAG_CLR) |
                   (paddr == `EWL_ADDR_STATUS) | (paddr == `EWL_ADDR_IRQ_STS) |
                   (paddr == `EWL_ADDR_IRQ_CLR) | (paddr == `EWL_ADDR_IRQ_EN) |
                   (paddr == `EWL_ADDR_LOWPWR);

  // one write strobe per writable register, byte lane 0 only
  assign wr_ctrl     = wr_acc & pstrb[0] & (paddr == `EWL_ADDR_CTRL);
  assign wr_flag_set = wr_acc & pstrb[0] & (paddr == `EWL_ADDR_FLAG_SET);
  assign wr_flag_clr = wr_acc & pstrb[0] & (paddr == `EWL_ADDR_FLAG_CLR);
  assign wr_irq_clr  = wr_acc & pstrb[0] & (paddr == `EWL_ADDR_IRQ_CLR);
  assign wr_irq_en   = wr_acc & pstrb[0] & (paddr == `EWL_ADDR_IRQ_EN);
  assign wr_lowpwr   = wr_acc & pstrb[0] & (paddr == `EWL_ADDR_LOWPWR);
  assign in_isr      = (state == ST_ISR);
  assign return_from_irq_instr_seen   = in_isr & return_from_irq_instr;

  // falling edge of busy marks end of write cycle
  assign nvm_done_pulse = nvm_busy_d & ~nvm_write_busy;

  assign all_flags = {ext_flag, nvm_write_done_flag};
  assign flag_rise = |(all_flags & ~flags_d);

  // call only with every enable, a pending request and stack room
  assign take_vector = (state == ST_IDLE) & global_irq_enable & nvm_write_done_enable &
                       group_enable & group_request_flag & ~stack_full;

  assign ev = {nvm_done_pulse, asleep & flag_rise, take_vector};

  // busy edge detector and per-source synchronisers
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      nvm_busy_d <= 1'b0;
      ext_meta   <= {EXT_SRC{1'b0}};
      ext_sync   <= {EXT_SRC{1'b0}};
      ext_sync_d <= {EXT_SRC{1'b0}};
      flags_d    <= {(EXT_SRC+1){1'b0}};
    end else begin
      nvm_busy_d <= nvm_write_busy;
      ext_meta   <= ext_src_async;
      ext_sync   <= ext_meta;
      ext_sync_d <= ext_sync;
      flags_d    <= all_flags;
    end
  end

  // external source flags: set on rising edge, sticky, set beats clear
  genvar gi;
  generate
    for (gi = 0; gi < EXT_SRC; gi = gi + 1) begin : g_ext
      always @(posedge sys_clk) begin
        if (!rst_b) begin
          ext_flag[gi] <= 1'b0;
        end else if (ext_sync[gi] & ~ext_sync_d[gi]) begin
          ext_flag[gi] <= 1'b1;
        end else if (wr_flag_set & pwdata[gi+2]) begin
          ext_flag[gi] <= 1'b1;
        end else if (wr_flag_clr & pwdata[gi+2]) begin
          ext_flag[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // source flag: hardware set wins, only software clears
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      nvm_write_done_flag <= 1'b0;
    end else if (nvm_done_pulse) begin
      nvm_write_done_flag <= 1'b1;
    end else if (wr_flag_set & pwdata[`EWL_FLG_NVM]) begin
      nvm_write_done_flag <= 1'b1;
    end else if (wr_flag_clr & pwdata[`EWL_FLG_NVM]) begin
      nvm_write_done_flag <= 1'b0;
    end
  end

  // group flag: follows source, cleared by service or software
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      group_request_flag <= 1'b0;
    end else if (nvm_done_pulse) begin
      group_request_flag <= 1'b1;
    end else if (take_vector) begin
      group_request_flag <= 1'b0;
    end else if (wr_flag_set & pwdata[`EWL_FLG_GRP]) begin
      group_request_flag <= 1'b1;
    end else if (wr_flag_clr & pwdata[`EWL_FLG_GRP]) begin
      group_request_flag <= 1'b0;
    end
  end

  // service sequence
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take_vector) begin
          next_state = ST_CALL;
        end
      end
      ST_CALL: begin
        if (vector_ack) begin
          next_state = ST_ISR;
        end
      end
      ST_ISR: begin
        if (return_from_irq_instr | return_instr) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state      <= ST_IDLE;
      vector_req <= 1'b0;
      push_pc    <= 1'b0;
    end else begin
      state      <= next_state;
      vector_req <= (next_state == ST_CALL);
      push_pc    <= take_vector;
    end
  end

  // global enable: cleared on entry, restored by interrupt return or a ctrl write
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      global_irq_enable <= `EWL_GIE_RST;
    end else if (take_vector) begin
      global_irq_enable <= 1'b0;
    end else if (return_from_irq_instr_seen) begin
      global_irq_enable <= 1'b1;
    end else if (in_isr & return_instr) begin
      global_irq_enable <= global_irq_enable;
    end else if (wr_ctrl) begin
      global_irq_enable <= pwdata[`EWL_CTRL_GIE];
    end
  end

  // enables: clearing them only blocks service, flags stay
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      nvm_write_done_enable <= 1'b0;
      group_enable          <= 1'b0;
    end else if (wr_ctrl) begin
      nvm_write_done_enable <= pwdata[`EWL_CTRL_NVM_EN];
      group_enable          <= pwdata[`EWL_CTRL_GRP_EN];
    end
  end

  // wake pulse on any nvm or external flag rise while asleep, enables ignored
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= asleep & flag_rise;
    end
  end

  // low-power state, left on wake
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      asleep <= 1'b0;
    end else if (asleep & flag_rise) begin
      asleep <= 1'b0;
    end else if (wr_lowpwr) begin
      asleep <= pwdata[0];
    end
  end

  // interrupt status: event set wins over clear
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_sts <= 3'h0;
    end else if (wr_irq_clr) begin
      irq_sts <= (irq_sts & ~pwdata[2:0]) | ev;
    end else begin
      irq_sts <= irq_sts | ev;
    end
  end

  // interrupt enables
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_en <= 3'h0;
    end else if (wr_irq_en) begin
      irq_en <= pwdata[2:0];
    end
  end

  // level interrupt from enabled status bits
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_sts & irq_en);
    end
  end

  // read data mux, zero outside a read access
  always @* begin
    next_prdata = 32'h0;
    if (rd_acc) begin
      case (paddr)
        `EWL_ADDR_CTRL: begin
          next_prdata = {29'h0, group_enable, nvm_write_done_enable, global_irq_enable};
        end
        `EWL_ADDR_FLAGS: begin
          next_prdata = {{(30-EXT_SRC){1'b0}}, ext_flag, group_request_flag,
                         nvm_write_done_flag};
        end
        `EWL_ADDR_STATUS: begin
          next_prdata = {29'h0, in_isr, asleep, stack_full};
        end
        `EWL_ADDR_IRQ_STS: begin
          next_prdata = {29'h0, irq_sts};
        end
        `EWL_ADDR_IRQ_EN: begin
          next_prdata = {29'h0, irq_en};
        end
        `EWL_ADDR_LOWPWR: begin
          next_prdata = {31'h0, asleep};
        end
        default: begin
          next_prdata = 32'h0;
        end
      endcase
    end
  end

  // apb slave, one wait state
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
    end
  end

  // read data register, stands in the pready cycle only
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else begin
      prdata <= next_prdata;
    end
  end

endmodule // ewl_irq_wake

// File: verif/ewl_irq_wake_properties.sv
// checker for the nvm write-done interrupt block
// bound to the block, sees its ports only
`timescale 1ns/100ps
module ewl_irq_wake_properties (
  input wire sys_clk,
  input wire rst_b,
  input wire stack_full,
  input wire vector_ack,
  input wire return_from_irq_instr,
  input wire return_instr,
  input wire vector_req,
  input wire push_pc,
  input wire wake_req,
  input wire global_irq_enable
);
  reg in_isr;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // handler span as seen at the ports
  always @(posedge sys_clk) begin
    if (!rst_b || return_from_irq_instr || return_instr)
      in_isr <= 1'b0;
    else if (vector_req && vector_ack)
      in_isr <= 1'b1;
  end
  vec_gate_a: assert property ($rose(vector_req) |->
    $past(global_irq_enable) && !$past(stack_full)) else $error("bad vector call");
  gie_clear_a: assert property ($rose(vector_req) |-> !global_irq_enable)
    else $error("enable kept");
  push_only_a: assert property (push_pc |-> $rose(vector_req) ##1 !push_pc)
    else $error("bad push");
  vec_hold_a: assert property (vector_req && !vector_ack |=> vector_req)
    else $error("call dropped");
  vec_drop_a: assert property (vector_req && vector_ack |=> !vector_req)
    else $error("call kept");
  return_from_irq_instr_restore_a: assert property (in_isr && return_from_irq_instr |=> global_irq_enable)
    else $error("enable not restored");
  ret_keep_a: assert property (in_isr && return_instr |=> !global_irq_enable)
    else $error("enable changed");
  wake_pulse_a: assert property (wake_req |=> !wake_req)
    else $error("wake too long");
endmodule // ewl_irq_wake_properties

// File: verif/ewl_core_model.sv
// stand-in for the core sequencer and the nvm write controller
// same clock as the block; start_wr, dly, use_return_from_irq_instr come from the bench
`timescale 1ns/100ps
module ewl_core_model (
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire       start_wr,
  input  wire [3:0] dly,
  input  wire       use_return_from_irq_instr,
  input  wire       vector_req,
  output reg        nvm_write_busy,
  output reg        vector_ack,
  output reg        return_from_irq_instr,
  output reg        return_instr
);
  reg [4:0] cnt;
  reg [2:0] isr_cnt;
  always @(posedge sys_clk) begin
    vector_ack <= 1'b0;
    return_from_irq_instr <= 1'b0;
    return_instr <= 1'b0;
    cnt <= (nvm_write_busy || vector_req) ? cnt + 5'h1 : 5'h0;
    if (!rst_b) begin
      nvm_write_busy <= 1'b0;
      isr_cnt <= 3'h0;
    end else begin
      if (start_wr)
        nvm_write_busy <= 1'b1;
      else if (cnt == {1'b0, dly} + 5'h1)
        nvm_write_busy <= 1'b0;
      if (vector_req && !vector_ack && cnt == {1'b0, dly}) begin
        vector_ack <= 1'b1;
        isr_cnt <= 3'h5;
      end else if (isr_cnt != 3'h0)
        isr_cnt <= isr_cnt - 3'h1;
      return_from_irq_instr <= (isr_cnt == 3'h1) && use_return_from_irq_instr;
      return_instr <= (isr_cnt == 3'h1) && !use_return_from_irq_instr;
    end
  end
endmodule // ewl_core_model

// File: verif/ewl_irq_wake_tb.sv
// self-checking bench for the nvm write-done interrupt block
// drives apb, async sources and stack state; core model answers calls
`timescale 1ns/100ps
module ewl_irq_wake_tb;
  reg         sys_clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h0;
  reg  [31:0] pwdata = 32'h0;
  reg  [1:0]  ext_src_async = 2'h0;
  reg         stack_full = 1'b0;
  reg         start_wr = 1'b0;
  reg         use_return_from_irq_instr = 1'b1;
  reg  [3:0]  dly = 4'h0;
  reg  [31:0] seed = 32'hf1fed00d;
  wire [31:0] prdata;
  wire        pready, pslverr, nvm_write_busy, vector_ack, return_from_irq_instr;
  wire        return_instr, vector_req, push_pc, wake_req, global_irq_enable, irq;
  logic [33:0] notes[$];
  logic [33:0] exp;
  int          err_total = 0;
  int          n_compared = 0;
  int          cycles = 0;
  ewl_irq_wake u_ewl_irq_wake (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .nvm_write_busy, .ext_src_async,
    .stack_full, .vector_ack, .return_from_irq_instr, .return_instr, .vector_req,
    .push_pc, .wake_req, .global_irq_enable, .irq);
  ewl_core_model u_ewl_core_model (.sys_clk, .rst_b, .start_wr, .dly, .use_return_from_irq_instr,
    .vector_req, .nvm_write_busy, .vector_ack, .return_from_irq_instr, .return_instr);
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk iff pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // note {irq, pslverr, prdata} expected
  task rd(input logic [11:0] a, input logic [1:0] ie, input logic [31:0] d);
    notes.push_back({ie, d});
    apb(1'b0, a, 32'h0);
  endtask
  task nvm_write(input logic svc);
    seed = lfsr(seed);
    @(posedge sys_clk);
    dly <= seed[3:0];
    start_wr <= 1'b1;
    @(posedge sys_clk);
    start_wr <= 1'b0;
    @(posedge sys_clk iff !nvm_write_busy);
    if (svc)
      @(posedge sys_clk iff (return_from_irq_instr || return_instr));
    repeat (3) @(posedge sys_clk);
  endtask
  task report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      report_and_stop;
    end
    if (psel && penable && pready && !pwrite) begin
      exp = notes.pop_front();
      n_compared++;
      if ({irq, pslverr, prdata} !== exp) begin
        err_total++;
        $display("wrong value at %0t: got %h, expected %h", $time, {irq, pslverr, prdata}, exp);
      end
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b1, 12'h024, 32'hf);
    rd(12'h000, 2'b00, 32'h0);
    rd(12'h004, 2'b00, 32'h0);
    rd(12'h010, 2'b00, 32'h0);
    rd(12'h024, 2'b01, 32'h0);
    $display("test 1 done");
    apb(1'b1, 12'h01c, 32'h7);
    apb(1'b1, 12'h000, 32'h7);
    nvm_write(1'b1);
    rd(12'h000, 2'b10, 32'h7);
    rd(12'h004, 2'b10, 32'h1);
    apb(1'b1, 12'h01c, 32'h0);
    rd(12'h014, 2'b00, 32'h5);
    apb(1'b1, 12'h01c, 32'h7);
    apb(1'b1, 12'h018, 32'h7);
    apb(1'b1, 12'h00c, 32'h1);
    rd(12'h014, 2'b00, 32'h0);
    rd(12'h004, 2'b00, 32'h0);
    $display("test 2 done");
    apb(1'b1, 12'h01c, 32'h0);
    use_return_from_irq_instr <= 1'b0;
    nvm_write(1'b1);
    rd(12'h000, 2'b00, 32'h6);
    nvm_write(1'b0);
    apb(1'b1, 12'h000, 32'h0);
    rd(12'h004, 2'b00, 32'h3);
    stack_full <= 1'b1;
    apb(1'b1, 12'h000, 32'h7);
    rd(12'h010, 2'b00, 32'h1);
    use_return_from_irq_instr <= 1'b1;
    stack_full <= 1'b0;
    @(posedge sys_clk iff return_from_irq_instr);
    rd(12'h004, 2'b00, 32'h1);
    rd(12'h000, 2'b00, 32'h7);
    $display("test 3 done");
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h00c, 32'hf);
    apb(1'b1, 12'h018, 32'h7);
    apb(1'b1, 12'h01c, 32'h2);
    seed = lfsr(seed);
    apb(1'b1, 12'h008, 32'h4 << !seed[0]);
    apb(1'b1, 12'h020, 32'h1);
    rd(12'h010, 2'b00, 32'h2);
    ext_src_async[!seed[0]] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(12'h010, 2'b00, 32'h2);
    ext_src_async[seed[0]] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(12'h010, 2'b10, 32'h0);
    rd(12'h004, 2'b10, 32'hc);
    apb(1'b1, 12'h020, 32'h1);
    nvm_write(1'b0);
    rd(12'h010, 2'b10, 32'h0);
    $display("test 4 done");
    report_and_stop;
  end
endmodule // ewl_irq_wake_tb
bind ewl_irq_wake ewl_irq_wake_properties u_props (.sys_clk, .rst_b, .stack_full,
  .vector_ack, .return_from_irq_instr, .return_instr, .vector_req, .push_pc,
  .wake_req, .global_irq_enable);
